/* core/acr_pkg.sv */
package acr_pkg;
  localparam logic [7:0] IRQ_MASK_OFF = 8'h24;
  localparam logic [7:0] IRQ_RAW_OFF = 8'h28;
  localparam logic [7:0] IRQ_MSK_STAT_OFF = 8'h2c;
  localparam logic [7:0] IRQ_CLEAR_OFF = 8'h30;
  localparam logic [7:0] CONV_RESULT_OFF = 8'h34;
  localparam logic [7:0] GAIN_CAL_OFF = 8'h38;
  localparam logic [7:0] OFFSET_CAL_OFF = 8'h3c;
  localparam logic [7:0] DMA_CTRL_OFF = 8'h40;
  localparam logic [7:0] CAL_CTRL_OFF = 8'h44;
  localparam logic [7:0] RESULT_ALIAS_OFF = 8'h48;
  localparam int EOC_BIT = 0;
  localparam int OVR_BIT = 1;
  localparam int DMA_REQUEST_ENABLE_BIT = 0;
  localparam int CALIBRATION_ENABLE_BIT = 24;
  localparam int RESULT_W = 10;
  localparam int GAIN_W = 15;
  localparam int GAIN_FRAC_W = 14;
  localparam int OFFSET_W = 12;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef struct packed {
    logic conv_overrun;
    logic conv_done;
  } acr_irq_t;

  typedef struct packed {
    logic [31:0] rdata;
    logic [1:0] resp;
  } acr_rd_t;
endpackage

/* core/acr_regs.sv */
`timescale 1ns/1ns
module acr_regs #(
  parameter int RES_W = acr_pkg::RESULT_W
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic conv_done_in,
  input wire logic [RES_W-1:0] conv_data_in,
  output logic irq_out,
  output logic dma_request_enable_out,
  output logic dma_req_out
);
  logic [7:0] awaddr_r;
  logic [7:0] awaddr_nxt;
  logic aw_have_r;
  logic aw_have_nxt;
  logic [31:0] wdata_r;
  logic [31:0] wdata_nxt;
  logic [3:0] wstrb_r;
  logic [3:0] wstrb_nxt;
  logic w_have_r;
  logic w_have_nxt;
  logic bvalid_r;
  logic bvalid_nxt;
  logic [1:0] bresp_r;
  logic [1:0] bresp_nxt;

  logic rvalid_r;
  logic rvalid_nxt;
  acr_pkg::acr_rd_t rd_r;
  acr_pkg::acr_rd_t rd_nxt;

  acr_pkg::acr_irq_t raw_r;
  acr_pkg::acr_irq_t raw_nxt;
  acr_pkg::acr_irq_t mask_r;
  acr_pkg::acr_irq_t mask_nxt;
  logic [RES_W-1:0] result_r;
  logic [RES_W-1:0] result_nxt;
  logic unread_r;
  logic unread_nxt;
  logic [acr_pkg::GAIN_W-1:0] gain_r;
  logic [acr_pkg::GAIN_W-1:0] gain_nxt;
  logic [acr_pkg::OFFSET_W-1:0] offset_r;
  logic [acr_pkg::OFFSET_W-1:0] offset_nxt;
  logic dma_request_enable_r;
  logic dma_request_enable_nxt;
  logic calibration_enable_r;
  logic calibration_enable_nxt;
  logic dma_req_r;
  logic dma_req_nxt;

  logic wr_fire;
  logic rd_fire;
  logic rd_result;
  logic hit_mask;
  logic hit_clear;
  logic hit_gain;
  logic hit_offset;
  logic hit_dma;
  logic hit_cal;
  logic [31:0] gain_merged;
  logic [31:0] offset_merged;
  acr_pkg::acr_irq_t masked_stat;
  logic [31:0] wr_val;
  logic [RES_W-1:0] cal_value;

  function automatic logic [31:0] merge_strb(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] strb
  );
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction

  // clamp rather than wrap: a wrapped code would jump across the whole range
  function automatic logic [RES_W-1:0] saturate(
    input logic signed [16:0] v
  );
    if (v < 0) begin
      return '0;
    end else if (v > 17'sd1023) begin
      return '1;
    end
    return v[RES_W-1:0];
  endfunction

  function automatic logic [RES_W-1:0] calibrate(
    input logic [RES_W-1:0] raw,
    input logic [acr_pkg::OFFSET_W-1:0] offs,
    input logic [acr_pkg::GAIN_W-1:0] gain
  );
    logic signed [13:0] sum;
    logic signed [30:0] prod;
    logic signed [16:0] scaled;
    sum = $signed({4'h0, raw}) + $signed({{2{offs[acr_pkg::OFFSET_W-1]}}, offs});
    prod = sum * $signed({2'h0, gain});
    scaled = prod[30:14];
    return saturate(scaled);
  endfunction

  // one map for the write side, so holes and misaligned words answer with an error
  function automatic logic addr_mapped(
    input logic [7:0] a
  );
    logic ok;
    ok = 1'b0;
    if (a == acr_pkg::IRQ_MASK_OFF) begin
      ok = 1'b1;
    end else if (a == acr_pkg::IRQ_RAW_OFF) begin
      ok = 1'b1;
    end else if (a == acr_pkg::IRQ_MSK_STAT_OFF) begin
      ok = 1'b1;
    end else if (a == acr_pkg::IRQ_CLEAR_OFF) begin
      ok = 1'b1;
    end else if (a == acr_pkg::CONV_RESULT_OFF) begin
      ok = 1'b1;
    end else if (a == acr_pkg::GAIN_CAL_OFF) begin
      ok = 1'b1;
    end else if (a == acr_pkg::OFFSET_CAL_OFF) begin
      ok = 1'b1;
    end else if (a == acr_pkg::DMA_CTRL_OFF) begin
      ok = 1'b1;
    end else if (a == acr_pkg::CAL_CTRL_OFF) begin
      ok = 1'b1;
    end else if (a == acr_pkg::RESULT_ALIAS_OFF) begin
      ok = 1'b1;
    end
    return ok;
  endfunction

  assign wr_val = merge_strb(32'h0000_0000, wdata_r, wstrb_r);
  assign wr_fire = aw_have_r && w_have_r && !bvalid_r;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_result = rd_fire && s_axi_araddr == acr_pkg::CONV_RESULT_OFF;

  assign hit_mask = wr_fire && awaddr_r == acr_pkg::IRQ_MASK_OFF;
  assign hit_clear = wr_fire && awaddr_r == acr_pkg::IRQ_CLEAR_OFF;
  assign hit_gain = wr_fire && awaddr_r == acr_pkg::GAIN_CAL_OFF;
  assign hit_offset = wr_fire && awaddr_r == acr_pkg::OFFSET_CAL_OFF;
  assign hit_dma = wr_fire && awaddr_r == acr_pkg::DMA_CTRL_OFF;
  assign hit_cal = wr_fire && awaddr_r == acr_pkg::CAL_CTRL_OFF;

  // byte lanes not strobed keep the stored bits
  assign gain_merged = merge_strb({17'h0_0000, gain_r}, wdata_r, wstrb_r);
  assign offset_merged = merge_strb({20'h0_0000, offset_r}, wdata_r, wstrb_r);
  assign masked_stat = raw_r & mask_r;
  assign cal_value = calibration_enable_r ? calibrate(conv_data_in, offset_r, gain_r) : conv_data_in;

  assign s_axi_awready = !aw_have_r && clk_en_in;
  assign s_axi_wready = !w_have_r && clk_en_in;
  assign s_axi_arready = !rvalid_r && clk_en_in;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rd_r.rdata;
  assign s_axi_rresp = rd_r.resp;
  assign irq_out = |masked_stat;
  assign dma_request_enable_out = dma_request_enable_r;
  assign dma_req_out = dma_req_r;

  always_comb begin
    awaddr_nxt = awaddr_r;
    aw_have_nxt = aw_have_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    w_have_nxt = w_have_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    if (s_axi_awvalid && s_axi_awready) begin
      awaddr_nxt = s_axi_awaddr;
      aw_have_nxt = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
      w_have_nxt = 1'b1;
    end
    if (wr_fire) begin
      aw_have_nxt = 1'b0;
      w_have_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = acr_pkg::AXI_OKAY;
      if (!addr_mapped(awaddr_r)) begin
        bresp_nxt = acr_pkg::AXI_SLVERR;
      end
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
  end

  always_comb begin
    rvalid_nxt = rvalid_r;
    rd_nxt = rd_r;
    if (rd_fire) begin
      rvalid_nxt = 1'b1;
      rd_nxt.resp = acr_pkg::AXI_OKAY;
      rd_nxt.rdata = 32'h0000_0000;
      if (s_axi_araddr == acr_pkg::IRQ_MASK_OFF) begin
        rd_nxt.rdata[1:0] = mask_r;
      end else if (s_axi_araddr == acr_pkg::IRQ_RAW_OFF) begin
        rd_nxt.rdata[1:0] = raw_r;
      end else if (s_axi_araddr == acr_pkg::IRQ_MSK_STAT_OFF) begin
        rd_nxt.rdata[1:0] = masked_stat;
      end else if (s_axi_araddr == acr_pkg::IRQ_CLEAR_OFF) begin
        rd_nxt.rdata = 32'h0000_0000;
      end else if (s_axi_araddr == acr_pkg::CONV_RESULT_OFF || s_axi_araddr == acr_pkg::RESULT_ALIAS_OFF) begin
        rd_nxt.rdata[RES_W-1:0] = result_r;
      end else if (s_axi_araddr == acr_pkg::GAIN_CAL_OFF) begin
        rd_nxt.rdata[acr_pkg::GAIN_W-1:0] = gain_r;
      end else if (s_axi_araddr == acr_pkg::OFFSET_CAL_OFF) begin
        rd_nxt.rdata[acr_pkg::OFFSET_W-1:0] = offset_r;
      end else if (s_axi_araddr == acr_pkg::DMA_CTRL_OFF) begin
        rd_nxt.rdata[acr_pkg::DMA_REQUEST_ENABLE_BIT] = dma_request_enable_r;
      end else if (s_axi_araddr == acr_pkg::CAL_CTRL_OFF) begin
        rd_nxt.rdata[acr_pkg::CALIBRATION_ENABLE_BIT] = calibration_enable_r;
      end else begin
        rd_nxt.resp = acr_pkg::AXI_SLVERR;
      end
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  always_comb begin
    raw_nxt = raw_r;
    mask_nxt = mask_r;
    result_nxt = result_r;
    unread_nxt = unread_r;
    gain_nxt = gain_r;
    offset_nxt = offset_r;
    dma_request_enable_nxt = dma_request_enable_r;
    calibration_enable_nxt = calibration_enable_r;
    dma_req_nxt = 1'b0;

    // clears first, so a same-cycle conversion event wins
    if (hit_mask) begin
      mask_nxt = wr_val[1:0];
    end else if (hit_clear) begin
      raw_nxt = raw_r & ~wr_val[1:0];
    end else if (hit_gain) begin
      gain_nxt = gain_merged[acr_pkg::GAIN_W-1:0];
    end else if (hit_offset) begin
      offset_nxt = offset_merged[acr_pkg::OFFSET_W-1:0];
    end else if (hit_dma && wstrb_r[0]) begin
      dma_request_enable_nxt = wdata_r[acr_pkg::DMA_REQUEST_ENABLE_BIT];
    end else if (hit_cal && wstrb_r[3]) begin
      calibration_enable_nxt = wdata_r[acr_pkg::CALIBRATION_ENABLE_BIT];
    end

    // only the plain result address has the side effect; the alias reads clean
    if (rd_result) begin
      raw_nxt.conv_done = 1'b0;
      unread_nxt = 1'b0;
    end

    if (conv_done_in) begin
      result_nxt = cal_value;
      raw_nxt.conv_done = 1'b1;
      unread_nxt = 1'b1;
      dma_req_nxt = dma_request_enable_r;
      if (unread_r) begin
        raw_nxt.conv_overrun = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      awaddr_r <= 8'h00;
      aw_have_r <= 1'b0;
      wdata_r <= acr_pkg::REG_RESET;
      wstrb_r <= 4'h0;
      w_have_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= acr_pkg::AXI_OKAY;
    end else if (clk_en_in) begin
      awaddr_r <= awaddr_nxt;
      aw_have_r <= aw_have_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      w_have_r <= w_have_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rvalid_r <= 1'b0;
      rd_r <= '0;
    end else if (clk_en_in) begin
      rvalid_r <= rvalid_nxt;
      rd_r <= rd_nxt;
    end
  end

  // a conversion that ends while the enable is low is lost, not queued
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      raw_r <= '0;
      mask_r <= '0;
      result_r <= '0;
      unread_r <= 1'b0;
      gain_r <= '0;
      offset_r <= '0;
      dma_request_enable_r <= 1'b0;
      calibration_enable_r <= 1'b0;
      dma_req_r <= 1'b0;
    end else if (clk_en_in) begin
      raw_r <= raw_nxt;
      mask_r <= mask_nxt;
      result_r <= result_nxt;
      unread_r <= unread_nxt;
      gain_r <= gain_nxt;
      offset_r <= offset_nxt;
      dma_request_enable_r <= dma_request_enable_nxt;
      calibration_enable_r <= calibration_enable_nxt;
      dma_req_r <= dma_req_nxt;
    end
  end
endmodule

/* bench/acr_regs_monitor.sv */
`timescale 1ns/1ns
module acr_regs_monitor #(
  parameter int RES_W = acr_pkg::RESULT_W
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire logic s_axi_bvalid,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic conv_done_in,
  input wire logic irq_out,
  input wire logic dma_request_enable_out,
  input wire logic dma_req_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);
  wire logic rd_take = s_axi_arvalid && s_axi_arready;
  chk_dma_pulse: assert property (conv_done_in && clk_en_in && dma_request_enable_out |=> dma_req_out)
    else $error("dma request missing");
  chk_dma_cause: assert property (dma_req_out |-> $past(conv_done_in) && $past(dma_request_enable_out))
    else $error("dma request without cause");
  chk_irq_rise: assert property ($rose(irq_out) |-> $past(conv_done_in) || $rose(s_axi_bvalid))
    else $error("irq rose without event");
  chk_irq_fall: assert property ($fell(irq_out) |-> $rose(s_axi_bvalid) || $past(rd_take))
    else $error("irq fell without clear");
  chk_rd_answer: assert property (rd_take |=> s_axi_rvalid)
    else $error("read not answered");
  chk_rd_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answered twice");
  chk_clr_reads_zero: assert property (rd_take && s_axi_araddr == acr_pkg::IRQ_CLEAR_OFF |=> s_axi_rdata == 32'h0)
    else $error("clear register read not zero");
  chk_bad_addr: assert property (rd_take && s_axi_araddr[1:0] != 2'h0 |=> s_axi_rresp == acr_pkg::AXI_SLVERR)
    else $error("misaligned read not refused");
  cover property (rd_take && s_axi_araddr == acr_pkg::CONV_RESULT_OFF);
  cover property ($rose(irq_out));
  cover property (dma_req_out);
endmodule
bind acr_regs acr_regs_monitor #(.RES_W(RES_W)) u_mon (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
  .clk_en_in(clk_en_in), .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .conv_done_in(conv_done_in), .irq_out(irq_out),
  .dma_request_enable_out(dma_request_enable_out), .dma_req_out(dma_req_out));

/* bench/acr_conv_model.sv */
`timescale 1ns/1ns
module acr_conv_model (
  input wire logic clk_in,
  input wire logic start_in,
  input wire logic [3:0] lat_in,
  input wire logic [9:0] code_in,
  output logic conv_done_out,
  output logic [9:0] conv_data_out
);
  logic [4:0] wait_r = 5'h00;
  logic [9:0] held_r = 10'h000;
  initial conv_done_out = 1'b0;
  initial conv_data_out = 10'h000;
  // data toggles outside the done cycle so stale codes never match
  always @(posedge clk_in) begin
    if (start_in) begin
      wait_r <= {1'b0, lat_in} + 5'h01;
      held_r <= code_in;
    end else if (wait_r != 5'h00) begin
      wait_r <= wait_r - 5'h01;
    end
    conv_done_out <= (wait_r == 5'h01);
    conv_data_out <= (wait_r == 5'h01) ? held_r : ~conv_data_out;
  end
endmodule

/* bench/test_acr_regs.sv */
`timescale 1ns/1ns
module test_acr_regs;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, conv_done_in, irq_out, dma_en, dma_req;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [9:0] conv_data_in, conv_code = 10'h000;
  logic [3:0] conv_lat = 4'h0;
  logic conv_start = 1'b0;
  logic clk_en = 1'b1;
  int errors = 0, n_compared = 0, n_dma = 0;
  always #2 clk_in = ~clk_in;
  acr_regs dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .conv_done_in(conv_done_in), .conv_data_in(conv_data_in), .irq_out(irq_out),
    .dma_request_enable_out(dma_en), .dma_req_out(dma_req));
  acr_conv_model conv_core (.clk_in(clk_in), .start_in(conv_start), .lat_in(conv_lat), .code_in(conv_code),
    .conv_done_out(conv_done_in), .conv_data_out(conv_data_in));
  always @(posedge clk_in) n_dma <= n_dma + int'(dma_req === 1'b1);
  task automatic report_and_stop;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic b;
    b = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b) begin
      @(posedge clk_in);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      b = s_axi_bvalid;
    end
    s_axi_bready <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_in);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e);
  endtask
  task automatic conv(input logic [9:0] c);
    conv_start <= 1'b1;
    conv_code <= c;
    conv_lat <= 4'($urandom_range(3, 0));
    @(posedge clk_in);
    conv_start <= 1'b0;
    do @(posedge clk_in); while (!conv_done_in);
    repeat (2) @(posedge clk_in);
  endtask
  // negative sums clamp to zero whichever way the shift rounds
  function automatic logic [9:0] calib(input logic [9:0] r, input logic [11:0] o, input logic [14:0] g);
    int s;
    s = ((int'(r) + int'($signed(o))) * int'(g)) >>> 14;
    if (s < 0) return 10'h000;
    if (s > 1023) return 10'h3ff;
    return s[9:0];
  endfunction
  initial begin
    #100000;
    errors++;
    report_and_stop();
  end
  initial begin
    logic [31:0] d;
    logic [1:0] rr;
    logic [14:0] g;
    logic [11:0] o;
    logic [9:0] r;
    void'($urandom(32'h7aea));
    repeat (20) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_in);
    for (int a = 8'h24; a <= 8'h40; a += 4) rchk(8'(a), 32'h0);
    wr(acr_pkg::IRQ_MASK_OFF, 32'h3);
    rchk(acr_pkg::IRQ_MASK_OFF, 32'h3);
    wr(acr_pkg::IRQ_MASK_OFF, 32'h0);
    rchk(acr_pkg::IRQ_MASK_OFF, 32'h0);
    conv(10'h155);
    rchk(acr_pkg::IRQ_RAW_OFF, 32'h1);
    rchk(acr_pkg::IRQ_MSK_STAT_OFF, 32'h0);
    chk(irq_out, 32'h0);
    wr(acr_pkg::IRQ_MASK_OFF, 32'h1);
    chk(irq_out, 32'h1);
    rchk(acr_pkg::IRQ_MSK_STAT_OFF, 32'h1);
    rchk(acr_pkg::RESULT_ALIAS_OFF, 32'h155);
    rchk(acr_pkg::IRQ_RAW_OFF, 32'h1);
    rchk(acr_pkg::CONV_RESULT_OFF, 32'h155);
    rchk(acr_pkg::IRQ_RAW_OFF, 32'h0);
    chk(irq_out, 32'h0);
    conv(10'h2aa);
    conv(10'h0c3);
    rchk(acr_pkg::IRQ_RAW_OFF, 32'h3);
    wr(acr_pkg::IRQ_RAW_OFF, 32'h0);
    wr(acr_pkg::IRQ_CLEAR_OFF, 32'h0);
    rchk(acr_pkg::IRQ_RAW_OFF, 32'h3);
    wr(acr_pkg::IRQ_CLEAR_OFF, 32'h1);
    rchk(acr_pkg::IRQ_RAW_OFF, 32'h2);
    rchk(acr_pkg::IRQ_CLEAR_OFF, 32'h0);
    wr(acr_pkg::IRQ_MASK_OFF, 32'h2);
    chk(irq_out, 32'h1);
    rchk(acr_pkg::CONV_RESULT_OFF, 32'h0c3);
    wr(acr_pkg::IRQ_CLEAR_OFF, 32'h2);
    chk(irq_out, 32'h0);
    wr(acr_pkg::DMA_CTRL_OFF, 32'h1);
    chk(dma_en, 32'h1);
    conv(10'h011);
    chk(32'(n_dma), 32'h1);
    wr(acr_pkg::DMA_CTRL_OFF, 32'h0);
    conv(10'h022);
    chk(32'(n_dma), 32'h1);
    wr(acr_pkg::IRQ_CLEAR_OFF, 32'h3);
    wr(acr_pkg::CAL_CTRL_OFF, 32'h0100_0000);
    for (int i = 0; i < 8; i++) begin
      g = (i == 0) ? 15'h7fff : 15'h2000 + 15'($urandom_range(24575, 0));
      o = (i == 0) ? 12'h7ff : (i == 1) ? 12'h800 : 12'($urandom);
      r = (i == 0) ? 10'h3ff : 10'($urandom);
      wr(acr_pkg::GAIN_CAL_OFF, {17'h0, g});
      rchk(acr_pkg::GAIN_CAL_OFF, {17'h0, g});
      wr(acr_pkg::OFFSET_CAL_OFF, {20'h0, o});
      rchk(acr_pkg::OFFSET_CAL_OFF, {20'h0, o});
      conv(r);
      rchk(acr_pkg::CONV_RESULT_OFF, {22'h0, calib(r, o, g)});
    end
    clk_en <= 1'b0;
    conv(10'h0aa);
    clk_en <= 1'b1;
    rchk(acr_pkg::RESULT_ALIAS_OFF, {22'h0, calib(r, o, g)});
    rd(8'h29, d, rr);
    chk(rr, acr_pkg::AXI_SLVERR);
    report_and_stop();
  end
endmodule
